// ### rtl/timer_cc_consts.vh
// Constants for the timer capture/compare block: register offsets,
// field positions, field codes and reset values.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef TIMER_CC_CONSTS_VH
`define TIMER_CC_CONSTS_VH

// ============================================================
// Register byte offsets on the Wishbone slave
`define TCC_ADDR_CTRL 8'h00
`define TCC_ADDR_COUNT 8'h04
`define TCC_ADDR_VECTOR 8'h08
`define TCC_CCTL_PAGE 3'h1
`define TCC_CVAL_PAGE 3'h2

// ============================================================
// Timer control register fields
`define TCC_MC 5:4
`define TCC_CLR 2
`define TCC_OVIE 1
`define TCC_OVFLG 0
`define TCC_MC_STOP 2'h0
`define TCC_MC_UP 2'h1
`define TCC_MC_CONT 2'h2
`define TCC_MC_UPDN 2'h3

// ============================================================
// Channel control register fields
`define TCC_CM 15:14
`define TCC_CAPTURE_INPUT_SEL 13:12
`define TCC_SCS 11
`define TCC_SHADOW_LOAD_SEL 10:9
`define TCC_CAP 8
`define TCC_OUTPUT_MODE_SEL 7:5
`define TCC_CHANNEL_IRQ_ENABLE 4
`define TCC_CCI 3
`define TCC_OUT 2
`define TCC_COV 1
`define TCC_FLAG 0
`define TCC_CM_RISE 2'h1
`define TCC_CM_FALL 2'h2
`define TCC_CM_BOTH 2'h3
`define TCC_CAPTURE_INPUT_SEL_A 2'h0
`define TCC_CAPTURE_INPUT_SEL_B 2'h1
`define TCC_CAPTURE_INPUT_SEL_GND 2'h2
`define TCC_SHADOW_LOAD_SEL_WRITE 2'h0
`define TCC_SHADOW_LOAD_SEL_ZERO 2'h1
`define TCC_SHADOW_LOAD_SEL_ZERO_PER 2'h2
`define TCC_OM_DIRECT 3'h0
`define TCC_OM_SET 3'h1
`define TCC_OM_TOG_RST 3'h2
`define TCC_OM_SET_RST 3'h3
`define TCC_OM_TOG 3'h4
`define TCC_OM_RST 3'h5
`define TCC_OM_TOG_SET 3'h6

// ============================================================
// Reset and fixed values
`define TCC_RST_COUNT 16'h0000
`define TCC_RST_CCTL 16'h0000
`define TCC_RST_CVAL 16'h0000
`define TCC_VEC_NONE 16'h0000
`define TCC_VEC_OVF 16'h000e
`define TCC_COUNT_MAX 16'hffff

`endif

// ### rtl/pin_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 14
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta <= {WIDTH{1'b0}};
      q_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ### rtl/cc_out_unit.v
// Output unit of one capture/compare channel.
// Assumes equal_in and period_in are one-cycle events on sys_clk_in.
`include "timer_cc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cc_out_unit (
  input wire clk_in,
  input wire rst_n_in,
  input wire [2:0] mode_in,
  input wire direct_in,
  input wire equal_in,
  input wire period_in,
  output reg out_out
);

  reg next_out;

  always @*
  begin
    next_out = out_out;
    if (mode_in == `TCC_OM_DIRECT)
      next_out = direct_in;
    else
    begin
      if (equal_in)
      begin
        if (mode_in == `TCC_OM_SET || mode_in == `TCC_OM_SET_RST)
          next_out = 1'b1;
        else if (mode_in == `TCC_OM_RST || mode_in == 3'h7)
          next_out = 1'b0;
        else
          next_out = ~out_out;
      end
      // Period event acts last, so it wins when both coincide
      if (period_in)
      begin
        if (mode_in == `TCC_OM_TOG_RST || mode_in == `TCC_OM_SET_RST)
          next_out = 1'b0;
        else if (mode_in == `TCC_OM_TOG_SET || mode_in == 3'h7)
          next_out = 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      out_out <= 1'b0;
    else
      out_out <= next_out;
  end

endmodule // cc_out_unit

`default_nettype wire

// ### rtl/timer_cc_top.v
// Timer counter with seven capture/compare channels behind a Wishbone slave.
// Assumes classic Wishbone on sys_clk_in; channel pins are asynchronous.
// Summary of operation
// - Count register holds the running 16-bit count, read and write.
// - Edge field: none, rising, falling or both edges trigger capture.
// - Input field selects input A, input B, ground or supply.
// - Sync bit adds a timer-clock stage before edge detection.
// - Shadow load: on value write, at zero, or at own compare match.
// - Shadow code two loads at zero, and also at period in up/down.
// - Capture select bit: zero compare, one capture.
// - Output mode picks direct, set, toggle, reset and paired actions.
// - Channel interrupt enable gates channel flag onto a request.
// - Input level bit reads the selected input's present level.
// - In mode zero the direct output bit drives the output.
// - Overrun bit set by hardware, cleared only by software.
// - In compare operation the compare latch, loaded from the value register, is compared with count.
// - A capture copies the current count into the value register.
// - Read-only interrupt vector register reads zero after reset.
// - Vector 02h..0Ch channels 1..6, 0Eh overflow, 00h none.
// - Overflow interrupt enable gates the overflow flag request.
`include "timer_cc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_cc_top (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [7:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output reg wb_ack_out,
  output reg [31:0] wb_dat_out,
  input wire [6:0] input_a_in,
  input wire [6:0] input_b_in,
  output wire [6:0] channel_out_out,
  output reg chan0_irq_out,
  output reg vector_irq_out
);

  localparam NCH = 7;

  reg [15:0] count_value;
  reg count_down;
  reg [1:0] mode_ctrl;
  reg overflow_irq_enable;
  reg overflow_flag;
  reg [15:0] ch_ctrl [0:NCH-1];
  reg [15:0] ch_value [0:NCH-1];
  reg [15:0] compare_latch [0:NCH-1];
  reg [15:0] next_ctrl [0:NCH-1];
  reg [15:0] next_value [0:NCH-1];
  reg [NCH-1:0] sel_level_d;
  reg [NCH-1:0] level_prev;
  reg [NCH-1:0] sel_level;
  reg [NCH-1:0] level_used;
  reg [NCH-1:0] cap_event;
  reg [NCH-1:0] equal_evt;
  reg [NCH-1:0] load_evt;
  reg [NCH-1:0] vec_clr;
  reg [15:0] next_count;
  reg next_down;
  reg wrap_evt;
  reg [15:0] vector;
  reg vec_is_ovf;
  reg [31:0] rdata;
  reg next_ovf_flag;
  wire [13:0] pin_level;
  wire run;
  wire at_zero;
  wire at_period;
  wire acc;
  wire wr_stb;
  wire rd_stb;
  wire [2:0] wch;
  wire cctl_hit;
  wire cval_hit;
  wire ctrl_wr;
  wire count_wr;
  wire vec_rd;
  integer i;
  integer vi;
  integer ni;
  integer ri;

  // ============================================================
  // Merge of a 16-bit register with the two low byte lanes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ============================================================
  // Bus decode
  assign acc = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_stb = acc & wb_we_in;
  assign rd_stb = acc & ~wb_we_in;
  assign wch = wb_adr_in[4:2];
  assign cctl_hit = (wb_adr_in[7:5] == `TCC_CCTL_PAGE) && (wch != 3'h7);
  assign cval_hit = (wb_adr_in[7:5] == `TCC_CVAL_PAGE) && (wch != 3'h7);
  assign ctrl_wr = wr_stb && (wb_adr_in == `TCC_ADDR_CTRL);
  assign count_wr = wr_stb && (wb_adr_in == `TCC_ADDR_COUNT);
  assign vec_rd = rd_stb && (wb_adr_in == `TCC_ADDR_VECTOR);

  // ============================================================
  // Input selection, synchronisation and edge detection
  pin_sync #(
    .WIDTH(14)
  ) u_pin_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({input_b_in, input_a_in}),
    .q_out(pin_level)
  );

  assign run = (mode_ctrl != `TCC_MC_STOP);
  assign at_zero = run && (count_value == 16'h0000);
  assign at_period = run && (count_value == compare_latch[0]);

  always @*
  begin
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (ch_ctrl[i][`TCC_CAPTURE_INPUT_SEL] == `TCC_CAPTURE_INPUT_SEL_A)
        sel_level[i] = pin_level[i];
      else if (ch_ctrl[i][`TCC_CAPTURE_INPUT_SEL] == `TCC_CAPTURE_INPUT_SEL_B)
        sel_level[i] = pin_level[NCH+i];
      else
        sel_level[i] = (ch_ctrl[i][`TCC_CAPTURE_INPUT_SEL] != `TCC_CAPTURE_INPUT_SEL_GND);
      level_used[i] = ch_ctrl[i][`TCC_SCS] ? sel_level_d[i] : sel_level[i];
      cap_event[i] = ch_ctrl[i][`TCC_CAP] & (
        ((ch_ctrl[i][`TCC_CM] == `TCC_CM_RISE) & level_used[i] & ~level_prev[i]) |
        ((ch_ctrl[i][`TCC_CM] == `TCC_CM_FALL) & ~level_used[i] & level_prev[i]) |
        ((ch_ctrl[i][`TCC_CM] == `TCC_CM_BOTH) & (level_used[i] ^ level_prev[i])));
      equal_evt[i] = run && (count_value == compare_latch[i]);
      if (ch_ctrl[i][`TCC_SHADOW_LOAD_SEL] == `TCC_SHADOW_LOAD_SEL_WRITE)
        load_evt[i] = wr_stb && cval_hit && (wch == i[2:0]);
      else if (ch_ctrl[i][`TCC_SHADOW_LOAD_SEL] == `TCC_SHADOW_LOAD_SEL_ZERO)
        load_evt[i] = at_zero;
      else if (ch_ctrl[i][`TCC_SHADOW_LOAD_SEL] == `TCC_SHADOW_LOAD_SEL_ZERO_PER)
        load_evt[i] = at_zero || (at_period && mode_ctrl == `TCC_MC_UPDN);
      else
        load_evt[i] = equal_evt[i];
    end
  end

  // ============================================================
  // Interrupt vector, channel 1 highest, overflow lowest
  always @*
  begin
    vector = `TCC_VEC_NONE;
    vec_is_ovf = 1'b0;
    vec_clr = {NCH{1'b0}};
    if (overflow_flag && overflow_irq_enable)
    begin
      vector = `TCC_VEC_OVF;
      vec_is_ovf = 1'b1;
    end
    for (vi = NCH - 1; vi > 0; vi = vi - 1)
    begin
      if (ch_ctrl[vi][`TCC_FLAG] && ch_ctrl[vi][`TCC_CHANNEL_IRQ_ENABLE])
      begin
        vector = {12'h000, vi[2:0], 1'b0};
        vec_is_ovf = 1'b0;
        vec_clr = {NCH{1'b0}};
        vec_clr[vi] = vec_rd;
      end
    end
  end

  // ============================================================
  // Counter next state
  always @*
  begin
    next_count = count_value;
    next_down = count_down;
    wrap_evt = 1'b0;
    if (ctrl_wr && wb_sel_in[0] && wb_dat_in[`TCC_CLR])
    begin
      next_count = `TCC_RST_COUNT;
      next_down = 1'b0;
    end
    else if (count_wr)
      next_count = merge16(count_value, wb_dat_in, wb_sel_in);
    else if (mode_ctrl == `TCC_MC_UP)
    begin
      if (count_value >= compare_latch[0])
      begin
        next_count = 16'h0000;
        wrap_evt = 1'b1;
      end
      else
        next_count = count_value + 16'h0001;
    end
    else if (mode_ctrl == `TCC_MC_CONT)
    begin
      next_count = count_value + 16'h0001;
      wrap_evt = (count_value == `TCC_COUNT_MAX);
    end
    else if (mode_ctrl == `TCC_MC_UPDN)
    begin
      if (count_down)
      begin
        if (count_value <= 16'h0001)
        begin
          next_count = 16'h0000;
          next_down = 1'b0;
          wrap_evt = 1'b1;
        end
        else
          next_count = count_value - 16'h0001;
      end
      else if (count_value >= compare_latch[0])
      begin
        next_down = 1'b1;
        next_count = (count_value == 16'h0000) ? 16'h0000 : count_value - 16'h0001;
      end
      else
        next_count = count_value + 16'h0001;
    end
    next_ovf_flag = wrap_evt |
      ((ctrl_wr && wb_sel_in[0]) ? wb_dat_in[`TCC_OVFLG] : overflow_flag) &
      ~(vec_rd & vec_is_ovf);
  end

  // ============================================================
  // Channel register next state
  always @*
  begin
    for (ni = 0; ni < NCH; ni = ni + 1)
    begin
      next_ctrl[ni] = ch_ctrl[ni];
      next_value[ni] = ch_value[ni];
      if (wr_stb && cctl_hit && (wch == ni[2:0]))
        next_ctrl[ni] = merge16(ch_ctrl[ni], wb_dat_in, wb_sel_in);
      next_ctrl[ni][`TCC_CCI] = 1'b0;
      // Hardware set wins over a software or vector-read clear
      next_ctrl[ni][`TCC_FLAG] = cap_event[ni] |
        (~ch_ctrl[ni][`TCC_CAP] & equal_evt[ni]) |
        (next_ctrl[ni][`TCC_FLAG] & ~vec_clr[ni]);
      next_ctrl[ni][`TCC_COV] = (cap_event[ni] & ch_ctrl[ni][`TCC_FLAG]) |
        next_ctrl[ni][`TCC_COV];
      if (wr_stb && cval_hit && (wch == ni[2:0]))
        next_value[ni] = merge16(ch_value[ni], wb_dat_in, wb_sel_in);
      if (cap_event[ni])
        next_value[ni] = count_value;
    end
  end

  // ============================================================
  // Register state
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_value <= `TCC_RST_COUNT;
      count_down <= 1'b0;
      mode_ctrl <= `TCC_MC_STOP;
      overflow_irq_enable <= 1'b0;
      overflow_flag <= 1'b0;
      sel_level_d <= {NCH{1'b0}};
      level_prev <= {NCH{1'b0}};
      for (ri = 0; ri < NCH; ri = ri + 1)
      begin
        ch_ctrl[ri] <= `TCC_RST_CCTL;
        ch_value[ri] <= `TCC_RST_CVAL;
        compare_latch[ri] <= `TCC_RST_CVAL;
      end
    end
    else
    begin
      count_value <= next_count;
      count_down <= next_down;
      overflow_flag <= next_ovf_flag;
      if (ctrl_wr && wb_sel_in[0])
      begin
        mode_ctrl <= wb_dat_in[`TCC_MC];
        overflow_irq_enable <= wb_dat_in[`TCC_OVIE];
      end
      sel_level_d <= sel_level;
      level_prev <= level_used;
      for (ri = 0; ri < NCH; ri = ri + 1)
      begin
        ch_ctrl[ri] <= next_ctrl[ri];
        ch_value[ri] <= next_value[ri];
        if (load_evt[ri])
          compare_latch[ri] <= next_value[ri];
      end
    end
  end

  // ============================================================
  // Read mux and bus answer
  always @*
  begin
    rdata = 32'h0000_0000;
    if (wb_adr_in == `TCC_ADDR_CTRL)
      rdata = {26'h0, mode_ctrl, 2'b00, overflow_irq_enable, overflow_flag};
    else if (wb_adr_in == `TCC_ADDR_COUNT)
      rdata = {16'h0000, count_value};
    else if (wb_adr_in == `TCC_ADDR_VECTOR)
      rdata = {16'h0000, vector};
    else if (cctl_hit)
    begin
      rdata = {16'h0000, ch_ctrl[wch]};
      rdata[`TCC_CCI] = level_used[wch];
    end
    else if (cval_hit)
      rdata = {16'h0000, ch_value[wch]};
  end

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      chan0_irq_out <= 1'b0;
      vector_irq_out <= 1'b0;
    end
    else
    begin
      wb_ack_out <= acc;
      if (rd_stb)
        wb_dat_out <= rdata;
      chan0_irq_out <= ch_ctrl[0][`TCC_FLAG] & ch_ctrl[0][`TCC_CHANNEL_IRQ_ENABLE];
      vector_irq_out <= (vector != `TCC_VEC_NONE);
    end
  end

  // ============================================================
  // Output units; channel zero's match is the period event
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_out
      cc_out_unit u_out (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .mode_in(ch_ctrl[g][`TCC_OUTPUT_MODE_SEL]),
        .direct_in(ch_ctrl[g][`TCC_OUT]),
        .equal_in(equal_evt[g]),
        .period_in(equal_evt[0]),
        .out_out(channel_out_out[g])
      );
    end
  endgenerate

endmodule // timer_cc_top

`default_nettype wire

// ### verif/timer_cc_properties.sv
// Checker for the timer capture/compare block, seeing only its top ports.
// Assumes a bind from the bench top file onto timer_cc_top.
`timescale 1ns/1ps
`default_nettype none

module timer_cc_properties (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic chan0_irq_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ============================================================
  // Bus handshake
  ack_follow_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  ack_one_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without a request");
  ack_held_a: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
    else $error("ack outside a cycle");

  // ============================================================
  // Read data
  upper_zero_a: assert property (wb_dat_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  rdata_hold_a: assert property (!(wb_ack_out && !$past(wb_we_in)) |-> $stable(wb_dat_out))
    else $error("read data moved without a read");
  vector_code_a: assert property (wb_ack_out && $past(wb_adr_in) == 8'h08 && !$past(wb_we_in)
    |-> wb_dat_out[0] == 1'b0 && wb_dat_out[15:0] <= 16'h000e)
    else $error("vector code out of range");
  chan0_irq_a: assert property (wb_ack_out && $past(wb_adr_in) == 8'h20 && !$past(wb_we_in)
    |-> chan0_irq_out == (wb_dat_out[4] & wb_dat_out[0]))
    else $error("channel zero request not flag and enable");
endmodule // timer_cc_properties

`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the timer capture/compare block.
// Assumes rtl/ sources and the checker file are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [6:0] in_a = 7'h00;
  logic [6:0] in_b = 7'h00;
  wire ack;
  wire [31:0] rdat;
  wire [6:0] ch_out;
  wire irq0;
  wire irq_vec;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] rd;
  logic [15:0] cnt;
  logic [15:0] cap_val = 16'h0000;
  logic [1:0] cm;
  logic [1:0] sel;
  logic [1:0] k;
  logic [2:0] om;
  logic capture_sync_sel;
  logic lvl;

  always #5 sys_clk_in = ~sys_clk_in;

  timer_cc_top dut (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wb_adr_in(adr),
    .wb_dat_in(wdat),
    .wb_sel_in(4'h3),
    .wb_we_in(we),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_ack_out(ack),
    .wb_dat_out(rdat),
    .input_a_in(in_a),
    .input_b_in(in_b),
    .channel_out_out(ch_out),
    .chan0_irq_out(irq0),
    .vector_irq_out(irq_vec)
  );

  // ============================================================
  // Closing, compare and bus tasks
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled, then idles one cycle
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    we <= w;
    wdat <= {16'h0000, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: ack %h expected %h", $time, ack, 1'b1);
    end
    rd = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb_cycle(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    wb_cycle(a, 1'b0, 16'h0000);
    check(rd, exp);
  endtask

  // Counter passes c once, then stops
  task automatic run_over(input logic [15:0] c);
    wr(8'h04, c - 16'h0003);
    wr(8'h00, 16'h0020);
    repeat (8) @(posedge sys_clk_in);
    wr(8'h00, 16'h0000);
  endtask

  function automatic logic [7:0] cctl(input int n);
    return 8'(32'h20 + 4 * n);
  endfunction

  function automatic logic [7:0] cval(input int n);
    return 8'(32'h40 + 4 * n);
  endfunction

  // Only input A gets one pulse, so only that route yields edges
  function automatic logic [1:0] capture_count(input logic [1:0] m, input logic [1:0] s);
    if (s != 2'h0 || m == 2'h0)
      return 2'd0;
    return (m == 2'h3) ? 2'd2 : 2'd1;
  endfunction

  function automatic logic sel_level(input logic [1:0] s, input logic b);
    return (s == 2'h1) ? b : (s == 2'h3);
  endfunction

  // ============================================================
  // Watchdog
  initial
  begin
    #400000;
    error_cnt++;
    complete_run();
  end

  // ============================================================
  // Main sequence
  initial
  begin
    void'($urandom(95778));
    in_b <= 7'($urandom);
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h08, 16'h0000);
    rd_chk(8'h3c, 16'h0000);
    for (int n = 0; n < 7; n++)
    begin
      rd_chk(cctl(n), 16'h0000);
      rd_chk(cval(n), 16'h0000);
    end
    for (int i = 0; i < 4; i++)
    begin
      cnt = (i == 0) ? 16'hffff : 16'($urandom);
      wr(8'h04, cnt);
      rd_chk(8'h04, cnt);
    end
    // Vector priority and read clear
    for (int n = 0; n < 7; n++)
      wr(cctl(n), 16'h0011);
    wr(8'h00, 16'h0003);
    repeat (2) @(posedge sys_clk_in);
    check({14'h0, irq_vec, irq0}, 16'h0003);
    rd_chk(cctl(0), 16'h0011);
    for (int n = 1; n < 8; n++)
      rd_chk(8'h08, 16'(2 * n));
    rd_chk(8'h08, 16'h0000);
    wr(cctl(1), 16'h0001);
    wr(8'h00, 16'h0001);
    rd_chk(8'h08, 16'h0000);
    wr(8'h00, 16'h0000);
    for (int n = 0; n < 7; n++)
      wr(cctl(n), 16'h0000);
    // Capture edges, input routes, level readback and overrun
    for (int i = 0; i < 16; i++)
    begin
      cm = 2'(i >> 2);
      sel = 2'(i);
      capture_sync_sel = 1'($urandom);
      wr(cctl(2), {2'h0, sel, capture_sync_sel, 3'b001, 8'h00});
      repeat (6) @(posedge sys_clk_in);
      cnt = 16'($urandom);
      wr(8'h04, cnt);
      wr(cctl(2), {cm, sel, capture_sync_sel, 3'b001, 8'h00});
      in_a[2] <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      // New count between the edges tells rising from falling capture
      wr(8'h04, ~cnt);
      in_a[2] <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
      k = capture_count(cm, sel);
      if (k != 2'd0)
        cap_val = (cm == 2'h1) ? cnt : ~cnt;
      rd_chk(cval(2), cap_val);
      lvl = sel_level(sel, in_b[2]);
      rd_chk(cctl(2), {cm, sel, capture_sync_sel, 3'b001, 4'h0, lvl, 1'b0, k == 2'd2, k != 2'd0});
    end
    // Output modes set, reset and toggle on a compare match
    for (int m = 0; m < 3; m++)
    begin
      cnt = 16'h0100 + 16'($urandom % 32'hef00);
      lvl = (m == 1);
      om = (m == 0) ? 3'h1 : ((m == 1) ? 3'h5 : 3'h4);
      wr(cctl(3), {13'h0000, lvl, 2'h0});
      repeat (3) @(posedge sys_clk_in);
      check({15'h0, ch_out[3]}, {15'h0, lvl});
      wr(cval(3), cnt);
      wr(cctl(3), {8'h00, om, 5'h00});
      run_over(cnt);
      check({15'h0, ch_out[3]}, {15'h0, ~lvl});
      rd_chk(cctl(3), {8'h00, om, 5'h01});
    end
    // Shadow latch loads at zero versus on write
    wr(cctl(4), 16'h0200);
    wr(cval(4), cnt);
    run_over(cnt);
    rd_chk(cctl(4), 16'h0200);
    rd_chk(cval(4), cnt);
    wr(cctl(4), 16'h0000);
    wr(cval(4), cnt);
    run_over(cnt);
    rd_chk(cctl(4), 16'h0001);
    complete_run();
  end
endmodule // tb

bind timer_cc_top timer_cc_properties chk (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .wb_adr_in(wb_adr_in),
  .wb_we_in(wb_we_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out),
  .chan0_irq_out(chan0_irq_out)
);

`default_nettype wire
